// ==== shared/aftdt_pkg.sv ====
// Package: constants, field layout and types of the tone discriminator timer
package aftdt_pkg;

   // ****************************************
   // Clocking and count rate
   // ****************************************
   localparam int unsigned REF_PERIOD_NS = 8;          // 125 MHz reference clock
   localparam int unsigned COUNT_CLK_HZ = 1_250_000;   // Counter clock rate
   localparam int unsigned COUNT_PERIOD_NS = 800;      // One count period, 0.8 us
   localparam int unsigned COUNT_DIV = COUNT_PERIOD_NS / REF_PERIOD_NS;
   localparam int DIV_W = 7;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(COUNT_DIV - 1);

   // ****************************************
   // Bus addresses (address 1, address 0)
   // ****************************************
   localparam logic [1:0] ADDR_COUNT0 = 2'h0;
   localparam logic [1:0] ADDR_CONTROL = 2'h3;

   // ****************************************
   // Control word layout
   // ****************************************
   localparam int CW_SEL_HI = 7;
   localparam int CW_SEL_LO = 6;
   localparam int CW_RL_HI = 5;
   localparam int CW_RL_LO = 4;
   localparam int CW_MODE_HI = 3;
   localparam int CW_MODE_LO = 1;
   localparam int CW_BCD = 0;
   localparam logic [1:0] SEL_COUNTER0 = 2'h0;
   localparam logic [1:0] RL_LATCH = 2'h0;
   localparam logic [1:0] RL_LOW = 2'h1;
   localparam logic [1:0] RL_HIGH = 2'h2;
   localparam logic [1:0] RL_BOTH = 2'h3;

   // ****************************************
   // Reset values and counter constants
   // ****************************************
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_TC = 16'h0001;
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [3:0] BCD_DIGIT_ZERO = 4'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      MODE_TC_INT = 3'h0,
      MODE_ONESHOT = 3'h1,
      MODE_RATE = 3'h2,
      MODE_SQUARE = 3'h3,
      MODE_SW_STROBE = 3'h4,
      MODE_HW_STROBE = 3'h5
   } aftdt_mode_t;

   typedef enum logic [1:0] {
      CNT_IDLE = 2'b00,
      CNT_RUN = 2'b01,
      CNT_STROBE = 2'b11
   } aftdt_cnt_state_t;

endpackage

// ==== shared/aftdt_timer_if.sv ====
// Interface: link between bus front end and the counter zero engine
interface aftdt_timer_if;
   logic countEn;
   logic gateEdge;
   logic softStart;
   logic disarm;
   logic [15:0] countValue;
   logic bcdMode;
   aftdt_pkg::aftdt_mode_t mode;
   logic timerOut;
   logic [15:0] currentCount;

   modport ctrl (
      output countEn, gateEdge, softStart, disarm, countValue, bcdMode, mode,
      input timerOut, currentCount
   );
   modport timer (
      input countEn, gateEdge, softStart, disarm, countValue, bcdMode, mode,
      output timerOut, currentCount
   );
endinterface

// ==== src/aftdt_counter.sv ====
// Counter zero engine: binary or decade down counter with mode driven output
module aftdt_counter (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Link to front end
   aftdt_timer_if.timer tif
);

   typedef struct packed {
      logic [15:0] count;
      aftdt_pkg::aftdt_cnt_state_t state;
      logic outLevel;
   } aftdt_cnt_t;

   aftdt_cnt_t cur;
   aftdt_cnt_t next_cur;
   logic [4:0] borrow;
   logic [15:0] bcdDec;
   logic startHw;
   logic startSw;
   logic strobeMode;

   // ****************************************
   // Decade decrement, one borrow per digit
   // ****************************************
   assign borrow[0] = 1'b1;
   for (genvar d = 0; d < 4; d++) begin : gDecade
      logic [3:0] digit;
      assign digit = cur.count[4*d +: 4];
      assign borrow[d+1] = borrow[d] & (digit == aftdt_pkg::BCD_DIGIT_ZERO);
      assign bcdDec[4*d +: 4] = !borrow[d] ? digit :
         (digit == aftdt_pkg::BCD_DIGIT_ZERO) ? aftdt_pkg::BCD_DIGIT_MAX : digit - 4'h1;
   end

   // Start sources by mode
   assign startHw = tif.gateEdge & ((tif.mode == aftdt_pkg::MODE_ONESHOT) |
                                    (tif.mode == aftdt_pkg::MODE_HW_STROBE));
   assign startSw = tif.softStart & ((tif.mode == aftdt_pkg::MODE_TC_INT) |
                                     (tif.mode == aftdt_pkg::MODE_SW_STROBE));
   assign strobeMode = (tif.mode == aftdt_pkg::MODE_SW_STROBE) |
                       (tif.mode == aftdt_pkg::MODE_HW_STROBE);

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_cur = cur;
      if (tif.disarm) begin
         next_cur.state = aftdt_pkg::CNT_IDLE;
         next_cur.outLevel = (tif.mode != aftdt_pkg::MODE_TC_INT);
      end else if (tif.countEn) begin
         if (startHw | startSw) begin
            // A new edge restarts the full count, even mid run
            next_cur.count = tif.countValue;
            next_cur.state = aftdt_pkg::CNT_RUN;
            next_cur.outLevel = strobeMode;
         end else begin
            unique case (cur.state)
               aftdt_pkg::CNT_IDLE: begin
                  next_cur.state = aftdt_pkg::CNT_IDLE;
               end
               aftdt_pkg::CNT_RUN: begin
                  if (cur.count == aftdt_pkg::COUNT_TC) begin
                     next_cur.count = aftdt_pkg::COUNT_RESET;
                     next_cur.outLevel = !strobeMode;
                     next_cur.state = strobeMode ? aftdt_pkg::CNT_STROBE : aftdt_pkg::CNT_IDLE;
                  end else begin
                     next_cur.count = tif.bcdMode ? bcdDec : cur.count - 16'h0001;
                  end
               end
               aftdt_pkg::CNT_STROBE: begin
                  next_cur.outLevel = 1'b1;
                  next_cur.state = aftdt_pkg::CNT_IDLE;
               end
               default: begin
                  next_cur.state = aftdt_pkg::CNT_IDLE;
               end
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cur <= '{count: aftdt_pkg::COUNT_RESET, state: aftdt_pkg::CNT_IDLE, outLevel: 1'b1};
      end else begin
         cur <= next_cur;
      end
   end

   assign tif.timerOut = cur.outLevel;
   assign tif.currentCount = cur.count;

endmodule

// ==== src/aftdt_top.sv ====
// Top: tone edge doubler, bus programmed counter zero and converter output gating
module aftdt_top #(
   parameter int TONE_DELAY_TAPS = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Module control bus, counter port
   input wire logic chipSelectN,
   input wire logic readN,
   input wire logic writeN,
   input wire logic [1:0] busAddr,
   input wire logic [7:0] busDataIn,
   output logic [7:0] busDataOut,
   output logic busDataOe,
   // Tone inputs
   input wire logic rxTone,
   input wire logic keyerTone,
   input wire logic toneLoopbackSelect,
   // Converter path controls
   input wire logic detectedLevel,
   input wire logic signalPresentN,
   input wire logic converterHold,
   input wire logic converterSenseInvert,
   // Outputs
   output logic timerOut,
   output logic edgePulse,
   output logic converterOut,
   output logic signalPresentReadbackN,
   output logic converterReadback
);

   // ****************************************
   // State of the front end
   // ****************************************
   typedef struct packed {
      logic [aftdt_pkg::DIV_W-1:0] divCount;
      logic countEn;
      logic toneSel;
      logic [TONE_DELAY_TAPS-1:0] toneDelay;
      logic edgePulse;
      logic gatePrev;
      logic gatePending;
      logic softPending;
      logic disarm;
      logic writePrev;
      logic readPrev;
      logic [7:0] counterControlWord;
      logic [15:0] counterZeroCount;
      logic writeHigh;
      logic readHigh;
      logic armed;
      logic [7:0] dataOut;
      logic convOut;
      logic sigPresRb;
      logic convRb;
   } aftdt_top_state_t;

   aftdt_top_state_t cur;
   aftdt_top_state_t next_cur;
   aftdt_timer_if tif ();

   logic writeFall;
   logic readRise;
   logic readSel;
   logic gateRise;
   logic [1:0] cwSelect;
   logic [1:0] cwRl;
   logic [2:0] cwMode;
   logic [1:0] rlActive;
   logic gatedBit;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic aftdt_pkg::aftdt_mode_t decodeMode(input logic [2:0] field);
      aftdt_pkg::aftdt_mode_t m;
      // Upper bit is a don't care for the two periodic modes
      if (field[1]) begin
         m = field[0] ? aftdt_pkg::MODE_SQUARE : aftdt_pkg::MODE_RATE;
      end else begin
         m = aftdt_pkg::aftdt_mode_t'(field);
      end
      return m;
   endfunction

   // Control word fields as written on the bus
   assign cwSelect = busDataIn[aftdt_pkg::CW_SEL_HI:aftdt_pkg::CW_SEL_LO];
   assign cwRl = busDataIn[aftdt_pkg::CW_RL_HI:aftdt_pkg::CW_RL_LO];
   assign cwMode = busDataIn[aftdt_pkg::CW_MODE_HI:aftdt_pkg::CW_MODE_LO];
   assign rlActive = cur.counterControlWord[aftdt_pkg::CW_RL_HI:aftdt_pkg::CW_RL_LO];

   // ****************************************
   // Bus strobe decode
   // ****************************************
   // Falling write edge with the part selected and read idle
   assign writeFall = cur.writePrev & !writeN & !chipSelectN & readN;
   // End of a read of counter zero
   assign readRise = !cur.readPrev & readN & !chipSelectN & (busAddr == aftdt_pkg::ADDR_COUNT0);
   // Read of counter zero drives the data pins; address 11 stays off
   assign readSel = !chipSelectN & !readN & writeN &
                    (busAddr == aftdt_pkg::ADDR_COUNT0);
   assign gateRise = cur.edgePulse & !cur.gatePrev;

   // Converter gating and sense
   assign gatedBit = detectedLevel | signalPresentN | converterHold;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_cur = cur;
      next_cur.disarm = 1'b0;
      next_cur.writePrev = writeN;
      next_cur.readPrev = readN;

      // Count clock enable from the reference clock
      if (cur.divCount == aftdt_pkg::DIV_LAST) begin
         next_cur.divCount = '0;
         next_cur.countEn = 1'b1;
      end else begin
         next_cur.divCount = cur.divCount + aftdt_pkg::DIV_W'(1);
         next_cur.countEn = 1'b0;
      end

      // Tone source and edge doubler
      next_cur.toneSel = toneLoopbackSelect ? keyerTone : rxTone;
      next_cur.toneDelay = {cur.toneDelay[TONE_DELAY_TAPS-2:0], cur.toneSel};
      next_cur.edgePulse = cur.toneSel ^ cur.toneDelay[TONE_DELAY_TAPS-1];
      next_cur.gatePrev = cur.edgePulse;

      // Starts wait for the next count clock; a new one beats the consume
      if (cur.countEn) begin
         next_cur.gatePending = 1'b0;
         next_cur.softPending = 1'b0;
      end
      if (gateRise & cur.armed) begin
         next_cur.gatePending = 1'b1;
      end

      // Control word write
      if (writeFall & (busAddr == aftdt_pkg::ADDR_CONTROL)) begin
         if ((cwSelect == aftdt_pkg::SEL_COUNTER0) & (cwRl != aftdt_pkg::RL_LATCH)) begin
            next_cur.counterControlWord = busDataIn;
            next_cur.writeHigh = (cwRl == aftdt_pkg::RL_HIGH);
            next_cur.readHigh = (cwRl == aftdt_pkg::RL_HIGH);
            next_cur.armed = 1'b0;
            next_cur.gatePending = 1'b0;
            next_cur.softPending = 1'b0;
            next_cur.disarm = 1'b1;
         end
      end

      // Count byte write
      if (writeFall & (busAddr == aftdt_pkg::ADDR_COUNT0)) begin
         unique case (rlActive)
            aftdt_pkg::RL_LOW: begin
               next_cur.counterZeroCount = {aftdt_pkg::BYTE_ZERO, busDataIn};
               next_cur.armed = 1'b1;
               next_cur.softPending = 1'b1;
            end
            aftdt_pkg::RL_HIGH: begin
               next_cur.counterZeroCount = {busDataIn, aftdt_pkg::BYTE_ZERO};
               next_cur.armed = 1'b1;
               next_cur.softPending = 1'b1;
            end
            aftdt_pkg::RL_BOTH: begin
               if (!cur.writeHigh) begin
                  next_cur.counterZeroCount[7:0] = busDataIn;
                  next_cur.writeHigh = 1'b1;
                  next_cur.armed = 1'b0;
               end else begin
                  next_cur.counterZeroCount[15:8] = busDataIn;
                  next_cur.writeHigh = 1'b0;
                  next_cur.armed = 1'b1;
                  next_cur.softPending = 1'b1;
               end
            end
            default: begin
               next_cur.armed = cur.armed;
            end
         endcase
      end

      // Readback byte of the running count
      if (rlActive == aftdt_pkg::RL_HIGH) begin
         next_cur.dataOut = tif.currentCount[15:8];
      end else if ((rlActive == aftdt_pkg::RL_BOTH) & cur.readHigh) begin
         next_cur.dataOut = tif.currentCount[15:8];
      end else begin
         next_cur.dataOut = tif.currentCount[7:0];
      end
      if (readRise & (rlActive == aftdt_pkg::RL_BOTH)) begin
         next_cur.readHigh = !cur.readHigh;
      end

      // Converter output and readbacks
      next_cur.convOut = gatedBit ^ converterSenseInvert;
      next_cur.sigPresRb = signalPresentN;
      next_cur.convRb = detectedLevel;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cur <= '0;
         cur.writePrev <= 1'b1;
         cur.readPrev <= 1'b1;
         cur.counterControlWord <= aftdt_pkg::CONTROL_RESET;
         cur.counterZeroCount <= aftdt_pkg::COUNT_RESET;
         cur.convOut <= 1'b1;
         cur.sigPresRb <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // ****************************************
   // Counter engine
   // ****************************************
   assign tif.countEn = cur.countEn;
   assign tif.gateEdge = cur.gatePending;
   assign tif.softStart = cur.softPending;
   assign tif.disarm = cur.disarm;
   assign tif.countValue = cur.counterZeroCount;
   assign tif.bcdMode = cur.counterControlWord[aftdt_pkg::CW_BCD];
   assign tif.mode = decodeMode(
      cur.counterControlWord[aftdt_pkg::CW_MODE_HI:aftdt_pkg::CW_MODE_LO]);

   aftdt_counter aftdt_counter_inst (
      .ref_clk(ref_clk),
      .reset(reset),
      .tif(tif)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign busDataOut = cur.dataOut;
   assign busDataOe = readSel;
   assign timerOut = tif.timerOut;
   assign edgePulse = cur.edgePulse;
   assign converterOut = cur.convOut;
   assign signalPresentReadbackN = cur.sigPresRb;
   assign converterReadback = cur.convRb;

endmodule

// ==== tb/aftdt_monitor.sv ====
// Checker: port level assertions for the tone discriminator timer top
module aftdt_monitor #(
   parameter int TONE_DELAY_TAPS = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Control bus
   input wire logic chipSelectN,
   input wire logic readN,
   input wire logic writeN,
   input wire logic [1:0] busAddr,
   input wire logic [7:0] busDataIn,
   input wire logic [7:0] busDataOut,
   input wire logic busDataOe,
   // Tones and converter controls
   input wire logic rxTone,
   input wire logic keyerTone,
   input wire logic toneLoopbackSelect,
   input wire logic detectedLevel,
   input wire logic signalPresentN,
   input wire logic converterHold,
   input wire logic converterSenseInvert,
   // Outputs
   input wire logic timerOut,
   input wire logic edgePulse,
   input wire logic converterOut,
   input wire logic signalPresentReadbackN,
   input wire logic converterReadback
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // ****************************************
   // Helper logic
   // ****************************************
   logic [7:0] sincePulse;
   // Cycles since the last edge pulse, saturating
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sincePulse <= 8'hFF;
      end else if (edgePulse) begin
         sincePulse <= 8'h00;
      end else if (sincePulse != 8'hFF) begin
         sincePulse <= sincePulse + 8'h01;
      end
   end
   logic oneShotCfg;
   // One-shot mode flag of the last accepted counter zero control word
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         oneShotCfg <= 1'h0;
      end else if (!chipSelectN && !writeN && readN && busAddr == 2'h3 &&
                   busDataIn[7:4] inside {4'h1, 4'h2, 4'h3}) begin
         oneShotCfg <= busDataIn[3:1] == 3'h1;
      end
   end

   // ****************************************
   // Sequences and assertions
   // ****************************************
   sequence pulse_seen;
      ##[1:4] edgePulse;
   endsequence
   sequence held_low;
      !timerOut [*8];
   endsequence

   a_tone_edge_pulse: assert property ($changed(rxTone) && !toneLoopbackSelect
      && $stable(toneLoopbackSelect) |-> pulse_seen) else $error("no pulse after tone edge");
   a_pulse_ends: assert property ($rose(edgePulse) |-> ##[1:12] !edgePulse)
      else $error("edge pulse too wide");
   a_loop_tone: assert property ($changed(keyerTone) && toneLoopbackSelect
      && $stable(toneLoopbackSelect) |-> pulse_seen) else $error("loopback tone lost");
   a_mark_forced: assert property ((signalPresentN || converterHold)
      |=> converterOut == !$past(converterSenseInvert)) else $error("mark not forced");
   a_bit_passes: assert property (!signalPresentN && !converterHold |=>
      converterOut == ($past(detectedLevel) ^ $past(converterSenseInvert)))
      else $error("gated bit wrong");
   a_present_copy: assert property (1'h1 |=> signalPresentReadbackN == $past(signalPresentN))
      else $error("presence readback wrong");
   a_level_copy: assert property (1'h1 |=> converterReadback == $past(detectedLevel))
      else $error("converter readback wrong");
   a_read_enable: assert property (busDataOe ==
      (!chipSelectN && !readN && writeN && busAddr == 2'h0)) else $error("read enable wrong");
   a_low_min_width: assert property ($fell(timerOut) |=> held_low)
      else $error("timer low too short");
   a_fall_needs_edge: assert property ($fell(timerOut) && oneShotCfg
      |-> sincePulse <= 8'h78) else $error("timer fell without gate edge");
endmodule

bind aftdt_top aftdt_monitor #(.TONE_DELAY_TAPS(TONE_DELAY_TAPS)) aftdt_monitor_inst (
   .ref_clk(ref_clk), .reset(reset), .chipSelectN(chipSelectN), .readN(readN),
   .writeN(writeN), .busAddr(busAddr), .busDataIn(busDataIn), .busDataOut(busDataOut),
   .busDataOe(busDataOe), .rxTone(rxTone), .keyerTone(keyerTone),
   .toneLoopbackSelect(toneLoopbackSelect), .detectedLevel(detectedLevel),
   .signalPresentN(signalPresentN), .converterHold(converterHold),
   .converterSenseInvert(converterSenseInvert), .timerOut(timerOut), .edgePulse(edgePulse),
   .converterOut(converterOut), .signalPresentReadbackN(signalPresentReadbackN),
   .converterReadback(converterReadback)
);

// ==== tb/aftdt_cpu_model.sv ====
// Partner model: microprocessor on the counter port of the control bus
module aftdt_cpu_model (
   // Clock
   input wire logic ref_clk,
   // Bus driven by the processor
   output logic chipSelectN,
   output logic readN,
   output logic writeN,
   output logic [1:0] busAddr,
   output logic [7:0] busDataIn,
   // Read enable and data from the device
   input wire logic busDataOe,
   input wire logic [7:0] busDataOut
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle, deselected bus at time zero
   initial begin
      chipSelectN = 1'h1;
      readN = 1'h1;
      writeN = 1'h1;
      busAddr = 2'h0;
      busDataIn = 8'hA5;
   end
   // One write strobe, data held until the strobe is back high
   task automatic bus_write(input logic [1:0] a, input logic [7:0] d, input logic cs);
      @(posedge ref_clk);
      chipSelectN <= cs;
      busAddr <= a;
      busDataIn <= d;
      @(posedge ref_clk);
      writeN <= 1'h0;
      @(posedge ref_clk);
      @(posedge ref_clk);
      writeN <= 1'h1;
      @(posedge ref_clk);
      chipSelectN <= 1'h1;
      busDataIn <= ~d;
   endtask
   // One read strobe, returns the sampled output enable and data byte
   task automatic bus_read(input logic [1:0] a, input logic cs, output logic oe,
                           output logic [7:0] d);
      @(posedge ref_clk);
      chipSelectN <= cs;
      busAddr <= a;
      readN <= 1'h0;
      @(posedge ref_clk);
      @(posedge ref_clk);
      oe = busDataOe;
      d = busDataOut;
      // Strobe ends while still selected, so the byte pointer advances
      readN <= 1'h1;
      @(posedge ref_clk);
      chipSelectN <= 1'h1;
   endtask
endmodule

// ==== tb/aftdt_top_test.sv ====
// Testbench: converter path table, bus programming and one-shot timing
module aftdt_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   // Rows: level, absent, hold, sense, expected output
   localparam logic [4:0] CONV_ROWS [8] = '{5'h00, 5'h03, 5'h11, 5'h12, 5'h09, 5'h0A, 5'h05, 5'h06};
   logic ref_clk, reset, chipSelectN, readN, writeN, busDataOe, timerOut, edgePulse;
   logic rxTone, keyerTone, toneLoopbackSelect, detectedLevel, signalPresentN, converterHold;
   logic converterSenseInvert, converterOut, signalPresentReadbackN, converterReadback, oe;
   logic [1:0] busAddr;
   logic [7:0] busDataIn, busDataOut, rd;
   int err_count = 0;
   int n_checks = 0;

   aftdt_top #(.TONE_DELAY_TAPS(4)) aftdt_top_inst (
      .ref_clk(ref_clk), .reset(reset), .chipSelectN(chipSelectN), .readN(readN),
      .writeN(writeN), .busAddr(busAddr), .busDataIn(busDataIn), .busDataOut(busDataOut),
      .busDataOe(busDataOe), .rxTone(rxTone), .keyerTone(keyerTone),
      .toneLoopbackSelect(toneLoopbackSelect), .detectedLevel(detectedLevel),
      .signalPresentN(signalPresentN), .converterHold(converterHold),
      .converterSenseInvert(converterSenseInvert), .timerOut(timerOut), .edgePulse(edgePulse),
      .converterOut(converterOut), .signalPresentReadbackN(signalPresentReadbackN),
      .converterReadback(converterReadback));
   aftdt_cpu_model aftdt_cpu_model_inst (
      .ref_clk(ref_clk), .chipSelectN(chipSelectN), .readN(readN), .writeN(writeN),
      .busAddr(busAddr), .busDataIn(busDataIn), .busDataOe(busDataOe), .busDataOut(busDataOut));

   // ****************************************
   // Helper tasks
   // ****************************************
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'h1) begin
         err_count++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic give_up(input string msg);
      chk(1'h0, msg);
      tally_and_finish();
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic toggle_tone(input logic viaKeyer);
      @(posedge ref_clk);
      if (viaKeyer) keyerTone <= ~keyerTone;
      else rxTone <= ~rxTone;
   endtask
   task automatic wait_fall();
      int w;
      w = 0;
      while (timerOut !== 1'h0) begin
         @(posedge ref_clk);
         w++;
         if (w > 400) give_up("timer never fell");
      end
   endtask
   task automatic count_low(output int n);
      n = 0;
      while (timerOut === 1'h0) begin
         @(posedge ref_clk);
         n++;
         if (n > 70000) give_up("timer never rose");
      end
   endtask
   task automatic no_fall(input int n);
      logic bad;
      bad = 1'h0;
      repeat (n) begin
         @(posedge ref_clk);
         if (timerOut !== 1'h1) bad = 1'h1;
      end
      chk(!bad, "timer started while it should stay high");
   endtask

   // Clock at 125 MHz
   initial begin
      ref_clk = 1'h0;
      forever #4 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int n;
      int i;
      reset = 1'h1;
      {rxTone, keyerTone, toneLoopbackSelect} = 3'h0;
      {detectedLevel, signalPresentN, converterHold, converterSenseInvert} = 4'h0;
      cycles(10);
      chk(timerOut === 1'h1 && converterOut === 1'h1 && signalPresentReadbackN === 1'h1
          && converterReadback === 1'h0 && edgePulse === 1'h0, "reset values");
      cycles(10);
      reset <= 1'h0;
      // Converter gating table
      for (i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         {detectedLevel, signalPresentN, converterHold, converterSenseInvert} <= CONV_ROWS[i][4:1];
         cycles(2);
         chk(converterOut === CONV_ROWS[i][0], "converter output");
         chk(signalPresentReadbackN === CONV_ROWS[i][3] && converterReadback === CONV_ROWS[i][4],
             "readback");
      end
      @(posedge ref_clk);
      {signalPresentN, converterHold} <= 2'h0;
      // Read enable decode, selected and deselected
      for (i = 0; i < 4; i++) begin
         aftdt_cpu_model_inst.bus_read(2'(i), 1'h0, oe, rd);
         chk(oe === (i == 0), "read enable decode");
      end
      aftdt_cpu_model_inst.bus_read(2'h0, 1'h1, oe, rd);
      chk(oe === 1'h0, "deselected read");
      // Two-byte BCD one-shot, trigger before high byte is dropped
      aftdt_cpu_model_inst.bus_write(2'h3, 8'h33, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h0, 8'h56, 1'h0);
      toggle_tone(1'h0);
      no_fall(300);
      aftdt_cpu_model_inst.bus_write(2'h0, 8'h01, 1'h0);
      toggle_tone(1'h0);
      wait_fall();
      count_low(n);
      chk(n == 15600, "one-shot width for 156");
      // Retrigger restarts the full 312 count
      aftdt_cpu_model_inst.bus_write(2'h3, 8'h33, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h0, 8'h12, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h0, 8'h03, 1'h0);
      toggle_tone(1'h0);
      wait_fall();
      // Running count reads back low byte first, then high byte
      aftdt_cpu_model_inst.bus_read(2'h0, 1'h0, oe, rd);
      chk(rd === 8'h12, "count low byte read");
      aftdt_cpu_model_inst.bus_read(2'h0, 1'h0, oe, rd);
      chk(rd === 8'h03, "count high byte read");
      cycles(3000);
      toggle_tone(1'h0);
      count_low(n);
      chk(n >= 31200 && n <= 31400, "retriggered width for 312");
      // Binary count through the loopback tone
      aftdt_cpu_model_inst.bus_write(2'h3, 8'h32, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h0, 8'h10, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h0, 8'h00, 1'h0);
      @(posedge ref_clk);
      toneLoopbackSelect <= 1'h1;
      cycles(20);
      toggle_tone(1'h1);
      wait_fall();
      count_low(n);
      chk(n == 1600, "binary width via loopback");
      toggle_tone(1'h0);
      cycles(20);
      toneLoopbackSelect <= 1'h0;
      // Low byte only, then an illegal and a deselected control write
      aftdt_cpu_model_inst.bus_write(2'h3, 8'h12, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h0, 8'h20, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h3, 8'hD2, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h3, 8'h32, 1'h1);
      toggle_tone(1'h0);
      wait_fall();
      count_low(n);
      chk(n == 3200, "low byte only width");
      // Rate generator mode never starts a one-shot
      aftdt_cpu_model_inst.bus_write(2'h3, 8'h34, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h0, 8'h10, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h0, 8'h00, 1'h0);
      toggle_tone(1'h0);
      no_fall(400);
      // Hardware strobe: one count period low after two counts
      aftdt_cpu_model_inst.bus_write(2'h3, 8'h1A, 1'h0);
      aftdt_cpu_model_inst.bus_write(2'h0, 8'h02, 1'h0);
      toggle_tone(1'h0);
      wait_fall();
      count_low(n);
      chk(n == 100, "hardware strobe width");
      tally_and_finish();
   end
endmodule
